/* File: core/wdt_pkg.sv */
package wdt_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int SYS_CLK_HZ = 20000000;
  localparam int MS_PER_S = 1000;
  localparam logic [10:0] BASE_MS = 11'h010;
  localparam logic [10:0] RESET_HOLD_MS = 11'h005;
  localparam logic [10:0] MS_CNT_MAX = 11'h7ff;
  localparam logic [2:0] DEF_TIM = 3'h4;
  localparam logic [2:0] TIM_INVALID = 3'h7;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int MODE_HI = 15;
  localparam int MODE_LO = 13;
  localparam int TOG_POS = 12;
  localparam int CFG_POS = 11;
  localparam int WIN_POS = 10;
  localparam int TIM_HI = 9;
  localparam int TIM_LO = 7;
  localparam int OFF_POS = 6;
  localparam int KEY_HI = 5;
  localparam int KEY_LO = 0;
  localparam logic [5:0] UNLOCK_KEY = 6'h2a;
  localparam logic [5:0] WAKE_ADDR = 6'h01;

  // ----------------------------------------
  // Mode selection codes
  // ----------------------------------------
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_STOP = 3'h1;
  localparam logic [2:0] MODE_FLASH = 3'h2;
  localparam logic [2:0] MODE_READ = 3'h3;

  // ----------------------------------------
  // Failure status codes
  // ----------------------------------------
  localparam logic [1:0] RM_WD = 2'h2;
  localparam logic [2:0] LH_WD = 3'h3;

  // Watchdog states
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_CLOSED = 5'h02,
    ST_OPEN = 5'h04,
    ST_INHIBIT = 5'h08,
    ST_FAILED = 5'h10
  } wd_state_t;

endpackage

/* File: core/spi_frame_rx.sv */
`timescale 1ns/100ps
module spi_frame_rx (
  input wire logic spi_clk,
  input wire logic rst_n,
  input wire logic chip_select_low,
  input wire logic spi_mosi,
  output logic [15:0] frame_word,
  output logic frame_flag
);

  // ----------------------------------------
  // Shift stage, cleared while select is high
  // ----------------------------------------
  logic [15:0] shift; // Bits received so far
  logic [4:0] count; // Bit count, saturates
  logic [15:0] next_shift;
  logic [4:0] next_count;
  logic [15:0] next_word;
  logic next_flag;

  // Next shift values
  always_comb begin
    next_shift = {shift[14:0], spi_mosi};
    next_count = (count == 5'h11) ? count : count + 5'h01;
  end

  // Shift registers, reset by idle select
  always_ff @(posedge spi_clk or posedge chip_select_low) begin
    if (chip_select_low) begin
      shift <= 16'h0000;
      count <= 5'h00;
    end else begin
      shift <= next_shift;
      count <= next_count;
    end
  end

  // ----------------------------------------
  // Word hold and completion toggle
  // ----------------------------------------
  // Capture on the sixteenth bit only
  always_comb begin
    next_word = frame_word;
    next_flag = frame_flag;
    if (count == 5'h0f) begin
      next_word = next_shift;
      next_flag = ~frame_flag;
    end
  end

  // Held word stays stable until next frame
  always_ff @(posedge spi_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_word <= 16'h0000;
      frame_flag <= 1'b0;
    end else begin
      frame_word <= next_word;
      frame_flag <= next_flag;
    end
  end

endmodule

/* File: core/spi_window_watchdog.sv */
`timescale 1ns/100ps
module spi_window_watchdog #(
  parameter int TICKS_PER_MS = wdt_pkg::SYS_CLK_HZ / wdt_pkg::MS_PER_S
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic spi_clk,
  input wire logic chip_select_low,
  input wire logic spi_mosi,
  input wire logic [1:0] config_sel,
  input wire logic sw_dev_mode,
  input wire logic cyclic_wake,
  input wire logic bad_set_mask,
  output logic reset_out_pin,
  output logic restart_mode,
  output logic fail_safe_mode,
  output logic restart_cause_bit0,
  output logic restart_cause_bit1,
  output logic limp_status_bit0,
  output logic limp_status_bit1,
  output logic limp_status_bit2,
  output logic bad_setting_flag,
  output logic dev_reset_flag,
  output logic int_pulse,
  output logic [2:0] sbc_mode
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Full period in ms for a timing code
  function automatic logic [10:0] period_ms(input logic [2:0] code);
    period_ms = wdt_pkg::BASE_MS << code;
  endfunction

  // Frame modes that carry a refresh
  function automatic logic refresh_mode(input logic [2:0] m);
    refresh_mode = (m == wdt_pkg::MODE_NORMAL) ||
      (m == wdt_pkg::MODE_STOP) || (m == wdt_pkg::MODE_FLASH) ||
      (m == wdt_pkg::MODE_READ);
  endfunction

  // Stop or flash mode
  function automatic logic low_mode(input logic [2:0] m);
    low_mode = (m == wdt_pkg::MODE_STOP) || (m == wdt_pkg::MODE_FLASH);
  endfunction

  // ----------------------------------------
  // Link side receiver
  // ----------------------------------------
  logic [15:0] rx_word; // Held frame, link domain
  logic rx_flag; // Completion toggle, link domain

  spi_frame_rx u_rx (
    .spi_clk(spi_clk),
    .rst_n(rst_n),
    .chip_select_low(chip_select_low),
    .spi_mosi(spi_mosi),
    .frame_word(rx_word),
    .frame_flag(rx_flag)
  );

  // ----------------------------------------
  // Crossing into the system clock
  // ----------------------------------------
  logic cs_s1, cs_s2, cs_d1, cs_d2; // Select synchroniser
  logic fl_s1, fl_s2, fl_seen; // Toggle synchroniser
  logic frame_ok; // Complete frame taken
  logic [15:0] frame; // Word taken this cycle
  logic next_fl_seen, next_frame_ok;
  logic [15:0] next_frame;

  // Take the word four clock edges after select rise
  always_comb begin
    next_fl_seen = fl_seen;
    next_frame_ok = 1'b0;
    next_frame = frame;
    if (cs_d1 && !cs_d2) begin
      next_fl_seen = fl_s2;
      if (fl_s2 != fl_seen) begin
        next_frame_ok = 1'b1;
        next_frame = rx_word;
      end
    end
  end

  // Synchroniser and capture registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d1 <= 1'b1;
      cs_d2 <= 1'b1;
      fl_s1 <= 1'b0;
      fl_s2 <= 1'b0;
      fl_seen <= 1'b0;
      frame_ok <= 1'b0;
      frame <= 16'h0000;
    end else begin
      cs_s1 <= chip_select_low;
      cs_s2 <= cs_s1;
      cs_d1 <= cs_s2;
      cs_d2 <= cs_d1;
      fl_s1 <= rx_flag;
      fl_s2 <= fl_s1;
      fl_seen <= next_fl_seen;
      frame_ok <= next_frame_ok;
      frame <= next_frame;
    end
  end

  // ----------------------------------------
  // Frame fields
  // ----------------------------------------
  logic [2:0] f_mode; // Mode selection
  logic f_tog; // Refresh bit
  logic f_cfg; // Setting write request
  logic f_win; // Window mode request
  logic [2:0] f_tim; // Timing code request
  logic f_off; // Disable request
  logic [5:0] f_key; // Key or read address
  assign f_mode = frame[wdt_pkg::MODE_HI:wdt_pkg::MODE_LO];
  assign f_tog = frame[wdt_pkg::TOG_POS];
  assign f_cfg = frame[wdt_pkg::CFG_POS];
  assign f_win = frame[wdt_pkg::WIN_POS];
  assign f_tim = frame[wdt_pkg::TIM_HI:wdt_pkg::TIM_LO];
  assign f_off = frame[wdt_pkg::OFF_POS];
  assign f_key = frame[wdt_pkg::KEY_HI:wdt_pkg::KEY_LO];

  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  logic [15:0] tick_cnt; // Oscillator ticks in this ms
  logic [10:0] ms_cnt; // Ms since last service
  logic restart_tmr; // Zero both counters
  logic [15:0] next_tick;
  logic [10:0] next_ms;

  // Count ticks into milliseconds
  always_comb begin
    next_tick = tick_cnt + 16'h0001;
    next_ms = ms_cnt;
    if (tick_cnt == 16'(TICKS_PER_MS - 1)) begin
      next_tick = 16'h0000;
      if (ms_cnt != wdt_pkg::MS_CNT_MAX) begin
        next_ms = ms_cnt + 11'h001;
      end
    end
    if (restart_tmr) begin
      next_tick = 16'h0000;
      next_ms = 11'h000;
    end
  end

  // Timer registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 16'h0000;
      ms_cnt <= 11'h000;
    end else begin
      tick_cnt <= next_tick;
      ms_cnt <= next_ms;
    end
  end

  // ----------------------------------------
  // Watchdog control
  // ----------------------------------------
  wdt_pkg::wd_state_t state, next_state;
  logic last_tog, next_last_tog; // Last refresh bit written
  logic win_mode, next_win; // Window mode selected
  logic [2:0] tim, next_tim; // Timing code in use
  logic [2:0] next_sbc; // SBC operating mode
  logic unlock, next_unlock; // Previous frame unlocked
  logic wake_pend, next_wake; // Cyclic wake unread
  logic next_bad, next_dev, next_int;
  logic next_rst_out, next_rs, next_fs;
  logic [1:0] rm, next_rm; // Restart cause
  logic [2:0] lh, next_lh; // Limp status
  logic toggled; // Valid refresh toggle
  logic fail; // Watchdog failure now
  logic set_bad; // Bad setting event
  logic active; // Watchdog running
  logic [10:0] per; // Full period in ms
  logic [10:0] half; // Closed window length

  assign per = period_ms(tim);
  assign half = per >> 1;
  assign active = (state == wdt_pkg::ST_RUN) ||
    (state == wdt_pkg::ST_CLOSED) || (state == wdt_pkg::ST_OPEN);
  assign toggled = frame_ok && refresh_mode(f_mode) &&
    (f_tog != last_tog);

  // Next state of the whole watchdog
  always_comb begin
    next_state = state;
    next_last_tog = last_tog;
    next_win = win_mode;
    next_tim = tim;
    next_sbc = sbc_mode;
    next_unlock = unlock;
    next_wake = wake_pend;
    next_rst_out = reset_out_pin;
    next_rs = restart_mode;
    next_fs = fail_safe_mode;
    next_rm = rm;
    next_lh = lh;
    next_bad = bad_setting_flag;
    next_dev = dev_reset_flag;
    next_int = 1'b0;
    restart_tmr = 1'b0;
    fail = 1'b0;
    set_bad = 1'b0;
    // Refresh bit follows every refresh frame unless a failure reset clears it
    if (frame_ok && refresh_mode(f_mode)) begin
      next_last_tog = f_tog;
    end
    // Window and period timing
    case (state)
      wdt_pkg::ST_RUN: begin
        if (toggled) begin
          restart_tmr = 1'b1;
        end else if (ms_cnt >= per) begin
          fail = 1'b1;
        end
      end
      wdt_pkg::ST_CLOSED: begin
        if (toggled) begin
          fail = 1'b1;
        end else if (ms_cnt >= half) begin
          next_state = wdt_pkg::ST_OPEN;
        end
      end
      wdt_pkg::ST_OPEN: begin
        if (toggled) begin
          next_state = wdt_pkg::ST_CLOSED;
          restart_tmr = 1'b1;
        end else if (ms_cnt >= per) begin
          fail = 1'b1;
        end
      end
      wdt_pkg::ST_INHIBIT: begin
        // Old settings kept, timer starts in normal
        if (frame_ok && f_mode == wdt_pkg::MODE_NORMAL) begin
          next_state = win_mode ? wdt_pkg::ST_CLOSED :
            wdt_pkg::ST_RUN;
          restart_tmr = 1'b1;
        end
      end
      wdt_pkg::ST_FAILED: begin
        // Restart ends after the reset hold time
        if (restart_mode && ms_cnt >= wdt_pkg::RESET_HOLD_MS) begin
          next_state = wdt_pkg::ST_RUN;
          next_rst_out = 1'b1;
          next_rs = 1'b0;
          next_sbc = wdt_pkg::MODE_NORMAL;
          restart_tmr = 1'b1;
        end
      end
      default: begin
        next_state = wdt_pkg::ST_RUN;
      end
    endcase
    // Setting change in normal mode only
    if (frame_ok && f_cfg && active && !fail &&
        sbc_mode == wdt_pkg::MODE_NORMAL &&
        f_mode == wdt_pkg::MODE_NORMAL) begin
      if (!toggled || f_tim == wdt_pkg::TIM_INVALID) begin
        set_bad = 1'b1;
      end else begin
        next_win = f_win;
        next_tim = f_tim;
        next_state = f_win ? wdt_pkg::ST_CLOSED :
          wdt_pkg::ST_RUN;
        restart_tmr = 1'b1;
      end
    end
    // Protected disable request
    if (frame_ok && f_off && state != wdt_pkg::ST_INHIBIT) begin
      if (unlock && low_mode(f_mode) && low_mode(sbc_mode) &&
          active && !fail) begin
        next_state = wdt_pkg::ST_INHIBIT;
      end else begin
        set_bad = 1'b1;
      end
    end
    if (frame_ok) begin
      next_unlock = low_mode(f_mode) && !f_off &&
        (f_key == wdt_pkg::UNLOCK_KEY);
    end
    // Mode selection from frames
    if (frame_ok && low_mode(f_mode)) begin
      next_sbc = f_mode;
    end
    if (frame_ok && f_mode == wdt_pkg::MODE_NORMAL &&
        state != wdt_pkg::ST_FAILED) begin
      next_sbc = wdt_pkg::MODE_NORMAL;
    end
    // Cyclic wake must be read before the next
    if (frame_ok && f_mode == wdt_pkg::MODE_READ &&
        f_key == wdt_pkg::WAKE_ADDR) begin
      next_wake = 1'b0;
    end
    if (cyclic_wake && active && sbc_mode == wdt_pkg::MODE_STOP) begin
      if (wake_pend) begin
        fail = 1'b1;
      end
      next_wake = 1'b1;
    end
    // Read-only frame clears event flags
    if (frame_ok && f_mode == wdt_pkg::MODE_READ) begin
      next_bad = 1'b0;
      next_dev = 1'b0;
    end
    // Bad setting, set wins over clear
    if (set_bad) begin
      next_bad = 1'b1;
      next_int = !bad_set_mask;
    end
    // Failure reaction
    if (fail) begin
      if (sw_dev_mode) begin
        next_dev = 1'b1;
        next_int = 1'b1;
        next_state = win_mode ? wdt_pkg::ST_CLOSED :
          wdt_pkg::ST_RUN;
        restart_tmr = 1'b1;
      end else begin
        next_state = wdt_pkg::ST_FAILED;
        next_rst_out = 1'b0;
        next_rs = !config_sel[0];
        next_fs = config_sel[0];
        next_rm = wdt_pkg::RM_WD;
        next_lh = wdt_pkg::LH_WD;
        next_last_tog = 1'b0;
        next_win = 1'b0;
        next_tim = wdt_pkg::DEF_TIM;
        next_wake = 1'b0;
        restart_tmr = 1'b1;
      end
    end
  end

  // Watchdog registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= wdt_pkg::ST_RUN;
      last_tog <= 1'b0;
      win_mode <= 1'b0;
      tim <= wdt_pkg::DEF_TIM;
      sbc_mode <= wdt_pkg::MODE_NORMAL;
      unlock <= 1'b0;
      wake_pend <= 1'b0;
      reset_out_pin <= 1'b1;
      restart_mode <= 1'b0;
      fail_safe_mode <= 1'b0;
      rm <= 2'h0;
      lh <= 3'h0;
      bad_setting_flag <= 1'b0;
      dev_reset_flag <= 1'b0;
      int_pulse <= 1'b0;
    end else begin
      state <= next_state;
      last_tog <= next_last_tog;
      win_mode <= next_win;
      tim <= next_tim;
      sbc_mode <= next_sbc;
      unlock <= next_unlock;
      wake_pend <= next_wake;
      reset_out_pin <= next_rst_out;
      restart_mode <= next_rs;
      fail_safe_mode <= next_fs;
      rm <= next_rm;
      lh <= next_lh;
      bad_setting_flag <= next_bad;
      dev_reset_flag <= next_dev;
      int_pulse <= next_int;
    end
  end

  // Status bits straight from registers
  assign restart_cause_bit0 = rm[0];
  assign restart_cause_bit1 = rm[1];
  assign limp_status_bit0 = lh[0];
  assign limp_status_bit1 = lh[1];
  assign limp_status_bit2 = lh[2];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_fail_reset: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    fail && !sw_dev_mode |=> !reset_out_pin && restart_mode != fail_safe_mode)
    else $error("failure did not pull reset low");

  chk_open_after_closed: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    state == wdt_pkg::ST_CLOSED && ms_cnt >= half && !frame_ok &&
    !cyclic_wake |=> state == wdt_pkg::ST_OPEN)
    else $error("closed window did not open");

  chk_open_service: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    state == wdt_pkg::ST_OPEN && toggled && !f_cfg && !f_off &&
    !cyclic_wake |=> state == wdt_pkg::ST_CLOSED && ms_cnt == 11'h000)
    else $error("open service did not close window");

  chk_closed_toggle: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    state == wdt_pkg::ST_CLOSED && toggled && !sw_dev_mode |=>
    state == wdt_pkg::ST_FAILED ##1 !reset_out_pin)
    else $error("early toggle not treated as failure");

  chk_default_resume: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    $fell(state == wdt_pkg::ST_FAILED) |->
    tim == wdt_pkg::DEF_TIM && !win_mode && !last_tog && reset_out_pin)
    else $error("restart did not resume defaults");

  chk_bad_flag: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    set_bad |=> bad_setting_flag && $stable(tim) && $stable(win_mode))
    else $error("bad setting not flagged or applied");

  chk_inhibit_gate: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    $rose(state == wdt_pkg::ST_INHIBIT) |->
    $past(unlock) && low_mode($past(sbc_mode)))
    else $error("watchdog disabled without protocol");

  chk_status_bits: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    $rose(state == wdt_pkg::ST_FAILED) |->
    {restart_cause_bit1, restart_cause_bit0} == wdt_pkg::RM_WD &&
    {limp_status_bit2, limp_status_bit1, limp_status_bit0} ==
    wdt_pkg::LH_WD)
    else $error("failure not recorded in status");

endmodule

/* File: tb/mcu_link_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Controller end of the serial link
// ----------------------------------------
module mcu_link_model (
  input wire logic start,
  input wire logic [15:0] word,
  output logic busy,
  output logic spi_clk,
  output logic chip_select_low,
  output logic spi_mosi
);
  // One whole frame per start, clock still between frames
  initial begin
    busy = 1'b0;
    spi_clk = 1'b0;
    chip_select_low = 1'b1;
    spi_mosi = 1'b0;
    forever begin
      @(posedge start);
      busy = 1'b1;
      #20 chip_select_low = 1'b0;
      // Sixteen bits, top bit first
      for (int i = 15; i >= 0; i--) begin
        spi_mosi = word[i];
        #7.5 spi_clk = 1'b1;
        #7.5 spi_clk = 1'b0;
      end
      // Select rise hands the frame over
      #15 chip_select_low = 1'b1;
      // Released data line shows the inverse of its last bit
      spi_mosi = ~spi_mosi;
      // Select-high gap before the next frame
      #300 busy = 1'b0;
    end
  end
endmodule

/* File: tb/spi_window_watchdog_test.sv */
`timescale 1ns/100ps
module spi_window_watchdog_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  logic [15:0] word = 16'h0000;
  logic busy, spi_clk, chip_select_low, spi_mosi;
  logic [1:0] config_sel = 2'h0;
  logic sw_dev_mode = 1'b0;
  logic cyclic_wake = 1'b0;
  logic bad_set_mask = 1'b0;
  logic reset_out_pin, restart_mode, fail_safe_mode;
  logic restart_cause_bit0, restart_cause_bit1;
  logic limp_status_bit0, limp_status_bit1, limp_status_bit2;
  logic bad_setting_flag, dev_reset_flag, int_pulse;
  logic [2:0] sbc_mode;
  logic tog = 1'b0; // Refresh bit last sent
  int n_fail = 0;
  int n_compared = 0;
  int n_int = 0; // Interrupt pulses seen
  int cycles = 0;
  int n0;

  // Clock, 50 ns
  always #25 sys_clk = ~sys_clk;

  // Design with a four-cycle millisecond
  spi_window_watchdog #(.TICKS_PER_MS(4)) u_spi_window_watchdog (
    .sys_clk, .rst_n, .spi_clk, .chip_select_low, .spi_mosi,
    .config_sel, .sw_dev_mode, .cyclic_wake, .bad_set_mask,
    .reset_out_pin, .restart_mode, .fail_safe_mode,
    .restart_cause_bit0, .restart_cause_bit1, .limp_status_bit0,
    .limp_status_bit1, .limp_status_bit2, .bad_setting_flag,
    .dev_reset_flag, .int_pulse, .sbc_mode
  );

  // Controller model
  mcu_link_model u_mcu_link_model (
    .start, .word, .busy, .spi_clk, .chip_select_low, .spi_mosi
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Interrupt counting and hang limit
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (int_pulse === 1'b1) begin
      n_int <= n_int + 1;
    end
    if (cycles == 6000) begin
      n_fail = n_fail + 1;
      end_sim();
    end
  end

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Bounded wait on the model's busy flag
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (busy !== lvl && k < 100) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 100) begin
      n_fail++;
      end_sim();
    end
  endtask

  // One frame: mode, setting bits, disable bit, key
  task automatic frame(input logic [2:0] md, input logic [4:0] set,
                       input logic off, input logic [5:0] key);
    word <= {md, tog, set, off, key};
    start <= 1'b1;
    wait_busy(1'b1);
    start <= 1'b0;
    wait_busy(1'b0);
    tick(2);
  endtask

  // Frame carrying a toggled refresh bit
  task automatic serve(input logic [2:0] md, input logic [4:0] set);
    tog = ~tog;
    frame(md, set, 1'b0, 6'h00);
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    tick(5);
    rst_n <= 1'b1;
    tog = 1'b0;
    tick(2);
  endtask

  task automatic wake();
    cyclic_wake <= 1'b1;
    tick(1);
    cyclic_wake <= 1'b0;
    tick(3);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("reset_out_pin", reset_out_pin, 1'b1);
    check("sbc_mode", sbc_mode, wdt_pkg::MODE_NORMAL);
    check("bad_setting_flag", bad_setting_flag, 1'b0);
  endtask

  // One open-half service in a given mode, mode expected after it
  task automatic win_step(input logic [2:0] md, input logic [2:0] exp);
    tick(32);
    serve(md, 5'h00);
    check("sbc_mode", sbc_mode, exp);
    check("reset_out_pin", reset_out_pin, 1'b1);
  endtask

  // Window 16 ms, then serviced in the open half by each mode
  task automatic t_window();
    serve(wdt_pkg::MODE_NORMAL, 5'h18);
    win_step(wdt_pkg::MODE_STOP, wdt_pkg::MODE_STOP);
    win_step(wdt_pkg::MODE_FLASH, wdt_pkg::MODE_FLASH);
    win_step(wdt_pkg::MODE_READ, wdt_pkg::MODE_FLASH);
    win_step(wdt_pkg::MODE_NORMAL, wdt_pkg::MODE_NORMAL);
  endtask

  // Invalid timing code, unmasked then masked
  task automatic t_bad();
    for (int i = 0; i < 2; i++) begin
      bad_set_mask <= i[0];
      n0 = n_int;
      tick(32);
      serve(wdt_pkg::MODE_NORMAL, 5'h17);
      check("bad_setting_flag", bad_setting_flag, 1'b1);
      check("int_count", n_int - n0, 1 - i);
      tick(32);
      serve(wdt_pkg::MODE_READ, 5'h00);
      check("bad_setting_flag", bad_setting_flag, 1'b0);
      check("reset_out_pin", reset_out_pin, 1'b1);
    end
    bad_set_mask <= 1'b0;
  endtask

  // Toggle inside the closed half
  task automatic t_early();
    tick(5);
    serve(wdt_pkg::MODE_NORMAL, 5'h00);
    check("reset_out_pin", reset_out_pin, 1'b0);
    check("restart_mode", restart_mode, 1'b1);
    check("restart_cause", {restart_cause_bit1, restart_cause_bit0},
          wdt_pkg::RM_WD);
    check("limp", {limp_status_bit2, limp_status_bit1, limp_status_bit0},
          wdt_pkg::LH_WD);
    tick(10);
    check("reset_out_pin", reset_out_pin, 1'b0);
    tick(20);
    check("reset_out_pin", reset_out_pin, 1'b1);
    tog = 1'b0;
    serve(wdt_pkg::MODE_NORMAL, 5'h00);
    tick(200);
    check("reset_out_pin", reset_out_pin, 1'b1);
  endtask

  // Disable in stop, then return to normal
  task automatic t_inhibit();
    serve(wdt_pkg::MODE_NORMAL, 5'h18);
    tick(32);
    serve(wdt_pkg::MODE_STOP, 5'h00);
    frame(wdt_pkg::MODE_STOP, 5'h00, 1'b1, 6'h00);
    check("bad_setting_flag", bad_setting_flag, 1'b1);
    frame(wdt_pkg::MODE_STOP, 5'h00, 1'b0, wdt_pkg::UNLOCK_KEY);
    frame(wdt_pkg::MODE_STOP, 5'h00, 1'b1, 6'h00);
    tick(120);
    check("reset_out_pin", reset_out_pin, 1'b1);
    tog = 1'b1;
    // Asks for time-out mode, which must be ignored on the way out
    serve(wdt_pkg::MODE_NORMAL, 5'h13);
    check("sbc_mode", sbc_mode, wdt_pkg::MODE_NORMAL);
    tick(5);
    serve(wdt_pkg::MODE_NORMAL, 5'h00);
    check("reset_out_pin", reset_out_pin, 1'b0);
    tick(30);
  endtask

  // Cyclic wake in stop, read once then missed
  task automatic t_wake();
    tog = 1'b0;
    serve(wdt_pkg::MODE_NORMAL, 5'h00);
    serve(wdt_pkg::MODE_STOP, 5'h00);
    wake();
    tog = ~tog;
    frame(wdt_pkg::MODE_READ, 5'h00, 1'b0, wdt_pkg::WAKE_ADDR);
    wake();
    check("reset_out_pin", reset_out_pin, 1'b1);
    wake();
    check("reset_out_pin", reset_out_pin, 1'b0);
    tick(30);
  endtask

  // Missed service in development mode
  task automatic t_dev();
    tog = 1'b0;
    sw_dev_mode <= 1'b1;
    n0 = n_int;
    serve(wdt_pkg::MODE_NORMAL, 5'h10);
    tick(80);
    check("dev_reset_flag", dev_reset_flag, 1'b1);
    check("reset_out_pin", reset_out_pin, 1'b1);
    check("int_count", n_int - n0, 1);
    sw_dev_mode <= 1'b0;
  endtask

  // Missed 32 ms time-out in fail-safe config
  task automatic t_failsafe();
    do_reset();
    config_sel <= 2'h1;
    serve(wdt_pkg::MODE_NORMAL, 5'h11);
    tick(100);
    check("reset_out_pin", reset_out_pin, 1'b1);
    tick(40);
    check("reset_out_pin", reset_out_pin, 1'b0);
    check("fail_safe_mode", fail_safe_mode, 1'b1);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    t_reset();
    t_window();
    t_bad();
    t_early();
    t_inhibit();
    t_wake();
    t_dev();
    t_failsafe();
    end_sim();
  end
endmodule
